// ---- hw/ocgc_pkg.sv ----
// Package for the oscillator, PLL and clock gating control block.
// Assumes a 32-bit AXI4-Lite register bus on a single system clock.
package ocgc_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_SLOW_OSC = 8'h04;
    localparam logic [7:0] OFF_PLL = 8'h08;
    localparam logic [7:0] OFF_GATE = 8'h0c;
    localparam logic [7:0] OFF_EVT = 8'h10;
    localparam logic [7:0] OFF_FM_CFG1 = 8'h14;
    localparam logic [7:0] OFF_FM_CFG2 = 8'h18;
    localparam logic [7:0] OFF_FM_CTRL = 8'h1c;
    localparam logic [7:0] OFF_FM_CNT = 8'h20;
    localparam logic [7:0] OFF_FM_RES = 8'h24;

    // Unlock field codes.
    localparam logic [1:0] UNL_STEP1 = 2'h1;
    localparam logic [1:0] UNL_STEP2 = 2'h2;
    localparam logic [1:0] UNL_OPEN = 2'h3;
    localparam logic [1:0] UNL_SHUT = 2'h0;

    // Slow oscillator register fields.
    localparam int SO_UNL_LSB = 30;
    localparam int SO_DONE_BIT = 29;
    localparam int SO_SEL_BIT = 28;
    localparam int SO_XEN_BIT = 27;
    localparam int SO_IRDY_BIT = 26;
    localparam int SO_XRDY_BIT = 25;
    localparam int SO_ICNT_LSB = 16;
    localparam int SO_XCNT_LSB = 0;

    // PLL register fields.
    localparam int PL_UNL_LSB = 30;
    localparam int PL_LOCK_BIT = 29;
    localparam int PL_EN_BIT = 28;
    localparam int PL_N_LSB = 24;
    localparam int PL_OD_LSB = 16;
    localparam int PL_M_LSB = 0;

    // Gate, event timer and measurement fields.
    localparam int GT_UNL_LSB = 30;
    localparam int EV_EN_BIT = 8;
    localparam int FM_START_BIT = 0;
    localparam int FM_RSTN_BIT = 1;
    localparam int FM_MODE_BIT = 2;
    localparam int FM_SEL_BIT = 3;
    localparam int FM_REFEN_BIT = 4;
    localparam int FM_DONE_BIT = 31;
    localparam int FM_PASS_BIT = 30;

    // Reset values.
    localparam logic [4:0] RST_ICNT = 5'h10;
    localparam logic [15:0] RST_XCNT = 16'h0400;
    localparam logic [3:0] RST_N = 4'h0;
    localparam logic [1:0] RST_OD = 2'h0;
    localparam logic [13:0] RST_M = 14'h0000;
    localparam logic [7:0] RST_EVDIV = 8'h80;
    localparam logic [15:0] RST_PLL_WAIT = 16'h0100;
    localparam logic [1:0] IRC_DIV = 2'h3;

    // Measurement unit state.
    typedef enum logic [1:0] {FM_IDLE, FM_RUN, FM_DONE} ocgc_fm_e;

    // Slow oscillator status carried as one group.
    typedef struct packed {
        logic irdy;
        logic xrdy;
        logic sw_done;
    } ocgc_osc_s;

endpackage

// ---- hw/ocgc_top.sv ----
// Clock control register set: slow oscillators, PLL, gating, event clock
// and frequency measurement, behind an AXI4-Lite slave.
// Assumes core_clk is the system clock and slow oscillator clocks arrive
// as asynchronous pins that are synchronised here.
//
// Contract
// - Unlock fields open their register after 01, 10, 11 written in order.
// - Writing 00 to an open unlock field relocks; other values are kept.
// - Writes to read-only or reserved bits are dropped with OKAY response.
// - Internal oscillator is ready after its settle count in units of four slow cycles.
// - Crystal is ready after its settle count in 128 kHz cycles.
// - Ready flags read 1 after the settle count, 0 otherwise.
// - Watchdog switch done drops on select change, rises when switched.
// - Watchdog select 1 picks crystal, 0 picks internal oscillator.
// - Crystal enable bit turns the crystal on when set.
// - PLL lock flag rises after the lock wait count once enabled.
// - Input divider N is a four-bit direct value, reset zero.
// - Output divider codes give divide by 1, 2, 4 or 8.
// - Feedback divider M is a fourteen-bit direct value, reset zero.
// - A stop bit of 1 gates off that peripheral clock.
// - Stop bit positions map to fixed peripherals; bit 15 unused.
// - Event timer clock divides by twice the field plus one, reset 8'h80.
// - Event timer clock runs from system clock only when enabled.
// - Measurement target is a sixteen-bit software reference count.
// - Measurement start, reset-low, clock select and reference enable bits.
// - Only trace mode of the measurement unit works.
// - Result has done and pass flags; result valid when both set.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module ocgc_top
    import ocgc_pkg::*;
#(
    parameter int GATE_BITS = 30
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Slow oscillator clocks and controls.
    input wire logic irc_clk_pin,
    input wire logic pll_clk_pin,
    output logic crystal_enable,
    output logic watchdog_clock_select,
    // PLL controls.
    output logic pll_enable,
    output logic [3:0] pll_input_divider,
    output logic [1:0] pll_output_divider,
    output logic [13:0] pll_feedback_divider,
    output logic pll_lock_flag,
    // Peripheral gating and event timer clock.
    output logic [GATE_BITS-1:0] peripheral_stop_bits,
    output logic event_timer_clk
);

    if (GATE_BITS != 30) begin : g_bad_gate_bits
        $error("GATE_BITS must be 30");
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock field next state, shared by three registers.
    function automatic logic [1:0] unl_next(input logic [1:0] cur,
                                            input logic [1:0] wr);
        logic [1:0] r;
        r = cur;
        if (cur == UNL_OPEN) begin
            if (wr == UNL_SHUT) begin
                r = UNL_SHUT;
            end
        end else if (wr == UNL_STEP1) begin
            r = UNL_STEP1;
        end else if (wr == UNL_STEP2 && cur == UNL_STEP1) begin
            r = UNL_STEP2;
        end else if (wr == UNL_OPEN && cur == UNL_STEP2) begin
            r = UNL_OPEN;
        end else begin
            r = UNL_SHUT;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI write path: address and data are latched independently.
    logic aw_have_reg, w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;

    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign wr_fire = aw_have_reg && w_have_reg;

    // Capture address and data, then answer once both are present.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    // Byte-lane merge of write data into an old value.
    function automatic logic [31:0] merge(input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (w_strb_reg[i]) begin
                r[i*8 +: 8] = w_data_reg[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [7:0] off);
        return wr_fire && aw_addr_reg == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic [1:0] so_unl_reg, pl_unl_reg, gt_unl_reg;
    logic [4:0] icnt_reg;
    logic [15:0] xcnt_reg;
    logic [GATE_BITS-1:0] gate_reg;
    logic [7:0] evdiv_reg;
    logic ev_en_reg;
    logic [15:0] fm_target_reg, fm_hold_reg;
    logic [4:0] fm_ctrl_reg;
    logic [31:0] wv_so, wv_pl, wv_gt, wv_ev, wv_c1, wv_ct;
    logic pll_rewrite;

    assign wv_so = merge({so_unl_reg, 30'h0});
    assign wv_pl = merge({pl_unl_reg, 30'h0});
    assign wv_gt = merge({gt_unl_reg, 30'h0});
    assign wv_ev = merge({23'h0, ev_en_reg, evdiv_reg});
    assign wv_c1 = merge({fm_hold_reg, fm_target_reg});
    assign wv_ct = merge({27'h0, fm_ctrl_reg});
    assign pll_rewrite = hit(OFF_PLL) && pl_unl_reg == UNL_OPEN;

    // Locked registers accept writable bits only while their field is open.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            so_unl_reg <= UNL_SHUT;
            pl_unl_reg <= UNL_SHUT;
            gt_unl_reg <= UNL_SHUT;
            icnt_reg <= RST_ICNT;
            xcnt_reg <= RST_XCNT;
            watchdog_clock_select <= 1'b0;
            crystal_enable <= 1'b0;
            pll_enable <= 1'b0;
            pll_input_divider <= RST_N;
            pll_output_divider <= RST_OD;
            pll_feedback_divider <= RST_M;
            gate_reg <= '0;
        end else begin
            if (hit(OFF_SLOW_OSC)) begin
                so_unl_reg <= unl_next(so_unl_reg,
                                       wv_so[SO_UNL_LSB +: 2]);
                if (so_unl_reg == UNL_OPEN) begin
                    icnt_reg <= wv_so[SO_ICNT_LSB +: 5];
                    xcnt_reg <= wv_so[SO_XCNT_LSB +: 16];
                    watchdog_clock_select <= wv_so[SO_SEL_BIT];
                    crystal_enable <= wv_so[SO_XEN_BIT];
                end
            end
            if (hit(OFF_PLL)) begin
                pl_unl_reg <= unl_next(pl_unl_reg,
                                       wv_pl[PL_UNL_LSB +: 2]);
                if (pll_rewrite) begin
                    pll_enable <= wv_pl[PL_EN_BIT];
                    pll_input_divider <= wv_pl[PL_N_LSB +: 4];
                    pll_output_divider <= wv_pl[PL_OD_LSB +: 2];
                    pll_feedback_divider <= wv_pl[PL_M_LSB +: 14];
                end
            end
            if (hit(OFF_GATE)) begin
                gt_unl_reg <= unl_next(gt_unl_reg,
                                       wv_gt[GT_UNL_LSB +: 2]);
                if (gt_unl_reg == UNL_OPEN) begin
                    gate_reg <= wv_gt[GATE_BITS-1:0];
                end
            end
        end
    end
    // Bit 15 has no peripheral and is held at zero.
    assign peripheral_stop_bits = gate_reg & ~(30'h1 << 15);

    // Always-writable registers; reserved bits are simply dropped.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            evdiv_reg <= RST_EVDIV;
            ev_en_reg <= 1'b0;
            fm_target_reg <= 16'h0;
            fm_hold_reg <= 16'h0;
            fm_ctrl_reg <= 5'h0;
        end else begin
            if (hit(OFF_EVT)) begin
                evdiv_reg <= wv_ev[7:0];
                ev_en_reg <= wv_ev[EV_EN_BIT];
            end
            if (hit(OFF_FM_CFG1)) begin
                fm_target_reg <= wv_c1[15:0];
                fm_hold_reg <= wv_c1[31:16];
            end
            if (hit(OFF_FM_CTRL)) begin
                fm_ctrl_reg <= wv_ct[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronise the slow and PLL clocks, detect rising edges.
    logic [2:0] irc_sync_reg, pll_sync_reg;
    logic irc_rise, pll_rise;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irc_sync_reg <= 3'h0;
            pll_sync_reg <= 3'h0;
        end else begin
            irc_sync_reg <= {irc_sync_reg[1:0], irc_clk_pin};
            pll_sync_reg <= {pll_sync_reg[1:0], pll_clk_pin};
        end
    end
    assign irc_rise = irc_sync_reg[1] && !irc_sync_reg[2];
    assign pll_rise = pll_sync_reg[1] && !pll_sync_reg[2];

    // Settle counters; the internal one ticks on every fourth slow edge.
    logic [1:0] quarter_reg;
    logic [4:0] iwait_reg;
    logic [15:0] xwait_reg;
    logic sel_seen_reg;
    ocgc_osc_s osc_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quarter_reg <= 2'h0;
            iwait_reg <= 5'h0;
            xwait_reg <= 16'h0;
            sel_seen_reg <= 1'b0;
            osc_reg <= '{irdy: 1'b0, xrdy: 1'b0, sw_done: 1'b1};
        end else begin
            if (irc_rise) begin
                quarter_reg <= quarter_reg + 2'h1;
            end
            if (irc_rise && quarter_reg == IRC_DIV && !osc_reg.irdy) begin
                if (iwait_reg >= icnt_reg) begin
                    osc_reg.irdy <= 1'b1;
                end else begin
                    iwait_reg <= iwait_reg + 5'h1;
                end
            end
            if (!crystal_enable) begin
                xwait_reg <= 16'h0;
                osc_reg.xrdy <= 1'b0;
            end else if (irc_rise && !osc_reg.xrdy) begin
                if (xwait_reg >= xcnt_reg) begin
                    osc_reg.xrdy <= 1'b1;
                end else begin
                    xwait_reg <= xwait_reg + 16'h1;
                end
            end
            // Switch completes on the next internal oscillator edge, whichever source is selected.
            if (watchdog_clock_select != sel_seen_reg) begin
                osc_reg.sw_done <= 1'b0;
                if (irc_rise) begin
                    sel_seen_reg <= watchdog_clock_select;
                end
            end else begin
                osc_reg.sw_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL lock wait; restarts on disable or divider rewrite.
    logic [15:0] lock_wait_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lock_wait_reg <= 16'h0;
            pll_lock_flag <= 1'b0;
        end else if (!pll_enable || pll_rewrite) begin
            lock_wait_reg <= 16'h0;
            pll_lock_flag <= 1'b0;
        end else if (!pll_lock_flag) begin
            if (lock_wait_reg >= RST_PLL_WAIT) begin
                pll_lock_flag <= 1'b1;
            end else begin
                lock_wait_reg <= lock_wait_reg + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event timer clock: toggles after field plus one system cycles.
    logic [7:0] evcnt_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            evcnt_reg <= 8'h0;
            event_timer_clk <= 1'b0;
        end else if (!ev_en_reg) begin
            evcnt_reg <= 8'h0;
            event_timer_clk <= 1'b0;
        end else if (evcnt_reg >= evdiv_reg) begin
            evcnt_reg <= 8'h0;
            event_timer_clk <= !event_timer_clk;
        end else begin
            evcnt_reg <= evcnt_reg + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency measurement: reference is the system clock.
    ocgc_fm_e fm_state_reg;
    logic [15:0] ref_cnt_reg, test_cnt_reg;
    logic fm_done, cut_rise;
    assign cut_rise = fm_ctrl_reg[FM_SEL_BIT] ? pll_rise : irc_rise;
    assign fm_done = fm_state_reg == FM_DONE;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fm_state_reg <= FM_IDLE;
            ref_cnt_reg <= 16'h0;
            test_cnt_reg <= 16'h0;
        end else if (!fm_ctrl_reg[FM_RSTN_BIT]) begin
            fm_state_reg <= FM_IDLE;
            ref_cnt_reg <= 16'h0;
            test_cnt_reg <= 16'h0;
        end else begin
            case (fm_state_reg)
                FM_IDLE: begin
                    if (fm_ctrl_reg[FM_START_BIT] &&
                        fm_ctrl_reg[FM_MODE_BIT]) begin
                        fm_state_reg <= FM_RUN;
                    end
                end
                FM_RUN: begin
                    if (!fm_ctrl_reg[FM_START_BIT]) begin
                        fm_state_reg <= FM_IDLE;
                    end else if (ref_cnt_reg >= fm_target_reg) begin
                        fm_state_reg <= FM_DONE;
                    end else begin
                        if (fm_ctrl_reg[FM_REFEN_BIT]) begin
                            ref_cnt_reg <= ref_cnt_reg + 16'h1;
                        end
                        if (cut_rise) begin
                            test_cnt_reg <= test_cnt_reg + 16'h1;
                        end
                    end
                end
                FM_DONE: fm_state_reg <= FM_DONE;
                default: fm_state_reg <= FM_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: one-cycle answer, unmapped offsets read zero with OKAY.
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            OFF_SLOW_OSC: rd_mux = {so_unl_reg, osc_reg.sw_done,
                watchdog_clock_select, crystal_enable, osc_reg.irdy,
                osc_reg.xrdy, 4'h0, icnt_reg, xcnt_reg};
            OFF_PLL: rd_mux = {pl_unl_reg, pll_lock_flag, pll_enable,
                pll_input_divider, 6'h0, pll_output_divider, 2'h0,
                pll_feedback_divider};
            OFF_GATE: rd_mux = {gt_unl_reg, peripheral_stop_bits};
            OFF_EVT: rd_mux = {23'h0, ev_en_reg, evdiv_reg};
            OFF_FM_CFG1: rd_mux = {fm_hold_reg, fm_target_reg};
            OFF_FM_CTRL: rd_mux = {27'h0, fm_ctrl_reg};
            OFF_FM_CNT: rd_mux = {16'h0, test_cnt_reg};
            OFF_FM_RES: rd_mux = {fm_done, fm_done, 30'h0};
            default: rd_mux = 32'h0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ---- sim/ocgc_checker.sv ----
// Port-level checks for the clock control block.
// Assumes a bind onto ocgc_top, one clock and an active-low reset.
`timescale 1ns/10ps
module ocgc_checker
    import ocgc_pkg::*;
#(
    parameter int GATE_BITS = 30
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Register bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // PLL and gating outputs.
    input wire logic pll_enable,
    input wire logic [13:0] pll_feedback_divider,
    input wire logic pll_lock_flag,
    input wire logic [GATE_BITS-1:0] peripheral_stop_bits
);
    // One domain, so clock and reset are shared by every property.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER:
    assert property (wr_taken |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0)
        else $error("write answer late or not OKAY");
    AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    AST_NO_AW_B:
    assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("new write taken while answer pending");
    AST_RD_ANSWER:
    assert property (rd_taken |=> s_axi_rvalid && s_axi_rresp == 2'h0)
        else $error("read answer late or not OKAY");
    AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
    AST_GATE_GAP:
    assert property (!peripheral_stop_bits[15])
        else $error("unused stop bit set");
    AST_LOCK_OFF:
    assert property ($fell(pll_enable) |-> ##[0:1] !pll_lock_flag)
        else $error("lock kept after disable");
    AST_LOCK_WAIT:
    assert property ($rose(pll_lock_flag) |-> $past(pll_enable, 200))
        else $error("lock rose too soon after enable");
    AST_DIV_RELOCK:
    assert property ($changed(pll_feedback_divider) |-> ##[0:2] !pll_lock_flag)
        else $error("lock kept after divider rewrite");
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the clock control block.
// Assumes the slow clocks are sped up; they pace settle counts, the watchdog switch and measured counts.
`timescale 1ns/10ps
module tb
    import ocgc_pkg::*;
;
    logic core_clk = 1'h0, resetn = 1'h0, irc_clk_pin = 1'h0;
    logic pll_clk_pin = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, exp_q[$], msk_q[$];
    logic [3:0] s_axi_wstrb = 4'hf, pll_input_divider;
    logic [1:0] s_axi_bresp, s_axi_rresp, pll_output_divider;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, crystal_enable, watchdog_clock_select;
    logic pll_enable, pll_lock_flag, event_timer_clk;
    logic [13:0] pll_feedback_divider, m;
    logic [29:0] peripheral_stop_bits;
    logic [7:0] dv;
    logic [31:0] rnd = 32'h00015085;
    int n_fail = 0, checks = 0, n;
    ocgc_top #(.GATE_BITS(30)) dut (.*);
    ////////////////////////////////////////////////////////////////////
    // Slow clocks run fast so that settle counts stay short.
    always #5 core_clk = ~core_clk;
    always #40 irc_clk_pin = ~irc_clk_pin;
    always #20 pll_clk_pin = ~pll_clk_pin;
    function logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Address and data are offered together and dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        @(posedge core_clk iff (s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h1;
        @(posedge core_clk iff s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, 32'h0);
    endtask
    // The expectation is queued; the monitor below compares it.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(posedge core_clk iff s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        @(posedge core_clk iff s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    always @(posedge core_clk) begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
            chk(s_axi_rdata & msk_q.pop_front(), exp_q.pop_front());
            chk(s_axi_rresp, 32'h0);
        end
    end
    task automatic unl(input logic [7:0] a);
        wr(a, 32'h40000000);
        wr(a, 32'h80000000);
        wr(a, 32'hc0000000);
    endtask
    // Rising edges of the event clock over a window.
    task automatic rises(input int w, output int r);
        logic p;
        r = 0;
        p = event_timer_clk;
        repeat (w) begin
            @(posedge core_clk);
            r += int'(event_timer_clk === 1'h1 && p === 1'h0);
            p = event_timer_clk;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        rd(OFF_PLL, 32'h0, 32'hff033fff);
        rd(OFF_EVT, 32'h80, 32'h1ff);
        rd(OFF_SLOW_OSC, 32'h0, 32'h04000000);
        rd(8'h30, 32'h0, 32'hffffffff);
        wr(OFF_FM_RES, 32'hffffffff);
        rd(OFF_FM_RES, 32'h0, 32'hffffffff);
        d = xs();
        wr(OFF_GATE, {2'h3, d[29:0]});
        rd(OFF_GATE, 32'h0, 32'hffffffff);
        unl(OFF_GATE);
        wr(OFF_GATE, {2'h3, d[29:0]});
        chk(peripheral_stop_bits, d[29:0] & ~30'h8000);
        rd(OFF_GATE, {2'h3, d[29:0] & ~30'h8000}, 32'hffffffff);
        wr(OFF_GATE, 32'h80000000);
        rd(OFF_GATE, 32'hc0000000, 32'hc0000000);
        wr(OFF_GATE, 32'h0);
        wr(OFF_GATE, 32'hc0000001);
        rd(OFF_GATE, 32'h0, 32'hffffffff);
        unl(OFF_PLL);
        for (int od = 0; od < 4; od++) begin
            m = 14'(xs()) | 14'h0004;
            wr(OFF_PLL, {8'hd5, 6'h0, 2'(od), 2'h0, m});
            chk({pll_enable, pll_lock_flag, pll_input_divider,
                pll_output_divider, pll_feedback_divider},
                {2'h2, 4'h5, 2'(od), m});
        end
        n = 0;
        while (pll_lock_flag !== 1'h1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(n >= 250 && n <= 262), 32'h1);
        rd(OFF_PLL, 32'h20000000, 32'h20000000);
        wr(OFF_PLL, {8'hc5, 6'h0, 2'h3, 2'h0, m});
        chk(pll_lock_flag, 32'h0);
        for (int i = 0; i < 3; i++) begin
            dv = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs());
            wr(OFF_EVT, {23'h0, 1'h1, dv});
            repeat (520) @(posedge core_clk);
            rises(8 * (int'(dv) + 1), n);
            chk(n, 32'h4);
        end
        wr(OFF_EVT, 32'h0ff);
        rises(600, n);
        chk({n[30:0], event_timer_clk}, 32'h0);
        rd(OFF_SLOW_OSC, 32'h04000000, 32'h04000000);
        unl(OFF_SLOW_OSC);
        wr(OFF_SLOW_OSC, 32'hc8100004);
        chk(crystal_enable, 32'h1);
        rd(OFF_SLOW_OSC, 32'h0, 32'h02000000);
        repeat (100) @(posedge core_clk);
        rd(OFF_SLOW_OSC, 32'h02000000, 32'h02000000);
        wr(OFF_SLOW_OSC, 32'hd8100004);
        chk(watchdog_clock_select, 32'h1);
        repeat (40) @(posedge core_clk);
        rd(OFF_SLOW_OSC, 32'h30000000, 32'h30000000);
        wr(OFF_SLOW_OSC, 32'hc8100004);
        wr(OFF_SLOW_OSC, 32'hc0100004);
        chk({crystal_enable, watchdog_clock_select}, 32'h0);
        rd(OFF_SLOW_OSC, 32'h0, 32'h02000000);
        wr(OFF_FM_CFG1, 32'h64);
        wr(OFF_FM_CTRL, 32'h1b);
        repeat (150) @(posedge core_clk);
        rd(OFF_FM_RES, 32'h0, 32'h80000000);
        for (int s = 0; s < 2; s++) begin
            wr(OFF_FM_CTRL, 32'h0);
            wr(OFF_FM_CTRL, {27'h0, 1'h1, 1'(s), 3'h5});
            wr(OFF_FM_CTRL, {27'h0, 1'h1, 1'(s), 3'h7});
            repeat (150) @(posedge core_clk);
            rd(OFF_FM_RES, 32'hc0000000, 32'hc0000000);
            rd(OFF_FM_CNT, s ? 32'h10 : 32'h8, s ? 32'hfff0 : 32'hfff8);
        end
        repeat (4) @(posedge core_clk);
        test_done();
    end
endmodule
bind ocgc_top ocgc_checker #(.GATE_BITS(GATE_BITS)) u_chk (.*);
